// ==== core/asc_pkg.sv ====
// constants, state and mode types for the serial conversion control block
// assumes one clock (the conversion clock) and a synchronous active-low reset
//
// Functional notes
// - result shifts out serially, twelve bits, on clock
// - select low starts conversion, high stops it
// - two channel pins form a binary channel index
// - one-cycle strobe, data five cycles after fall
// - mode pins decode; first-high second-low disabled
// - single-shot halts after twelve bits, data low
// - single-shot result goes out msb first
// - continuous modes convert back to back while selected
// - lsb-first continuous; first bit twenty cycles after select
// - msb-first continuous mode sends msb first
// - after single-shot, data held low until deselect
`default_nettype none

package asc_pkg;

   // ----------------------------------------
   // sizes and timing in clock cycles
   // ----------------------------------------
   localparam int RES_BITS = 12;
   localparam int CNT_W = 4;
   localparam int SYNC_STAGES = 2;
   localparam int CS_TO_DATA_CYC = 20;
   localparam int STROBE_CYC = 1;
   localparam int GAP_CYC = 5;
   localparam int STROBE_TO_DATA_CYC = STROBE_CYC + GAP_CYC;
   // lead time after the synchronised select fall, so the pin sees twenty in total
   localparam logic [CNT_W-1:0] LEAD_INIT =
      CNT_W'(CS_TO_DATA_CYC - SYNC_STAGES - STROBE_TO_DATA_CYC - 1);
   localparam logic [CNT_W-1:0] GAP_INIT = CNT_W'(GAP_CYC - 1);
   localparam logic [CNT_W-1:0] BITS_LEFT_INIT = CNT_W'(RES_BITS - 1);
   localparam logic [CNT_W-1:0] LOAD_AT = 4'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [4:0] SYNC_RST = 5'h10;
   localparam logic [RES_BITS-1:0] WORD_RST = 12'h000;
   localparam logic [1:0] CHAN_RST = 2'h0;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      ASC_MODE_SINGLE = 2'h0,
      ASC_MODE_CONT_LSB = 2'h1,
      ASC_MODE_BAD = 2'h2,
      ASC_MODE_CONT_MSB = 2'h3
   } asc_mode_t;

   typedef enum logic [5:0]
   {
      ASC_ST_IDLE = 6'h01,
      ASC_ST_LEAD = 6'h02,
      ASC_ST_STROBE = 6'h04,
      ASC_ST_GAP = 6'h08,
      ASC_ST_SHIFT = 6'h10,
      ASC_ST_HALT = 6'h20
   } asc_state_t;

endpackage : asc_pkg

`default_nettype wire

// ==== core/asc_ser_if.sv ====
// carrier between the sequencer and the result shifter
// assumes both ends share the conversion clock
`default_nettype none

interface asc_ser_if;
   import asc_pkg::*;
   logic load;
   logic shift;
   logic lsb_first;
   logic [RES_BITS-1:0] word;
   logic bit_out;

   modport seq
   (
      output load,
      output shift,
      output lsb_first,
      output word,
      input bit_out
   );

   modport shifter
   (
      input load,
      input shift,
      input lsb_first,
      input word,
      output bit_out
   );
endinterface : asc_ser_if

`default_nettype wire

// ==== core/asc_shifter.sv ====
// result shift register, msb-first or lsb-first
// assumes load and shift come from the sequencer on the same clock
`default_nettype none

module asc_shifter
(
   input wire logic clock,
   input wire logic rst_b,
   asc_ser_if.shifter ser
);
   import asc_pkg::*;

   logic [RES_BITS-1:0] sh_r;

   // ----------------------------------------
   // shift register
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         sh_r <= WORD_RST;
      end
      else if (ser.load)
      begin
         sh_r <= ser.word;
      end
      else if (ser.shift)
      begin
         sh_r <= ser.lsb_first ? (sh_r >> 1) : (sh_r << 1);
      end
   end

   assign ser.bit_out = ser.lsb_first ? sh_r[0] : sh_r[RES_BITS-1];

endmodule // asc_shifter

`default_nettype wire

// ==== core/asc_conv_ctrl.sv ====
// serial conversion control: select handling, mode decode, strobe and data out
// assumes cs_b, channel and mode pins are asynchronous; conv_result is on this clock
`default_nettype none

module asc_conv_ctrl
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic chan_sel_lo,
   input wire logic chan_sel_hi,
   input wire logic mode_sel_a,
   input wire logic mode_sel_b,
   input wire logic [asc_pkg::RES_BITS-1:0] conv_result,
   output logic data_out,
   output logic data_oe,
   output logic sample_strobe,
   output logic sample_strobe_oe,
   output logic [1:0] chan_index
);
   import asc_pkg::*;

   asc_ser_if ser ();

   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic cs_low;
   asc_mode_t mode_pins;
   asc_state_t state_r;
   asc_state_t state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   asc_mode_t mode_r;
   logic data_r;
   logic strobe_r;
   logic oe_r;
   logic [1:0] chan_r;
   logic emit;

   asc_shifter u_shifter
   (
      .clock(clock),
      .rst_b(rst_b),
      .ser(ser)
   );

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
      end
      else
      begin
         sync1_r <= {cs_b, chan_sel_hi, chan_sel_lo, mode_sel_a, mode_sel_b};
         sync2_r <= sync1_r;
      end
   end

   assign cs_low = !sync2_r[4];
   assign mode_pins = asc_mode_t'(sync2_r[1:0]);

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      emit = 1'b0;
      case (state_r)
         ASC_ST_IDLE:
         begin
            // the disabled pin code never starts a conversion
            if (cs_low && mode_pins != ASC_MODE_BAD)
            begin
               state_nxt = ASC_ST_LEAD;
               cnt_nxt = LEAD_INIT;
            end
         end
         ASC_ST_LEAD:
         begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == CNT_ZERO)
            begin
               state_nxt = ASC_ST_STROBE;
            end
         end
         ASC_ST_STROBE:
         begin
            state_nxt = ASC_ST_GAP;
            cnt_nxt = GAP_INIT;
         end
         ASC_ST_GAP:
         begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == CNT_ZERO)
            begin
               emit = 1'b1;
               state_nxt = ASC_ST_SHIFT;
               cnt_nxt = BITS_LEFT_INIT;
            end
         end
         ASC_ST_SHIFT:
         begin
            if (cnt_r != CNT_ZERO)
            begin
               emit = 1'b1;
               cnt_nxt = cnt_r - 4'h1;
            end
            else if (mode_r == ASC_MODE_SINGLE)
            begin
               state_nxt = ASC_ST_HALT;
            end
            else
            begin
               state_nxt = ASC_ST_STROBE;
            end
         end
         ASC_ST_HALT:
         begin
            state_nxt = ASC_ST_HALT;
         end
         default:
         begin
            state_nxt = ASC_ST_IDLE;
         end
      endcase
      // deselect always wins and restarts the sequence from idle
      if (!cs_low)
      begin
         state_nxt = ASC_ST_IDLE;
         cnt_nxt = CNT_ZERO;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         state_r <= ASC_ST_IDLE;
         cnt_r <= CNT_ZERO;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ----------------------------------------
   // mode capture
   // ----------------------------------------
   // caught on every idle cycle, last as the conversion starts; later pin changes are ignored until deselect
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         mode_r <= ASC_MODE_SINGLE;
      end
      else if (state_r == ASC_ST_IDLE)
      begin
         mode_r <= mode_pins;
      end
   end

   // ----------------------------------------
   // channel capture
   // ----------------------------------------
   // latched as the strobe rises, so a change made earlier applies to this sample
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         chan_r <= CHAN_RST;
      end
      else if (state_nxt == ASC_ST_STROBE && state_r != ASC_ST_STROBE)
      begin
         chan_r <= sync2_r[3:2];
      end
   end

   // ----------------------------------------
   // shifter control
   // ----------------------------------------
   // the result must be settled by the analog side within the gap after the strobe
   assign ser.load = (state_r == ASC_ST_GAP) && (cnt_r == LOAD_AT) && cs_low;
   assign ser.shift = emit && cs_low;
   assign ser.word = conv_result;
   assign ser.lsb_first = (mode_r == ASC_MODE_CONT_LSB);

   // ----------------------------------------
   // pin outputs
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         data_r <= 1'b0;
         strobe_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else
      begin
         oe_r <= cs_low;
         strobe_r <= (state_nxt == ASC_ST_STROBE) && (state_r != ASC_ST_STROBE);
         if (ser.shift)
         begin
            data_r <= ser.bit_out;
         end
         else if (state_nxt != ASC_ST_SHIFT)
         begin
            data_r <= 1'b0;
         end
      end
   end

   assign data_out = data_r;
   assign data_oe = oe_r;
   assign sample_strobe = strobe_r;
   assign sample_strobe_oe = oe_r;
   assign chan_index = chan_r;

endmodule // asc_conv_ctrl

`default_nettype wire

// ==== verification/asc_analog_model.sv ====
// analog side model: one fixed result word per selected channel
// assumes chan_index comes from the block under test, same clock
`default_nettype none

module asc_analog_model
(
   input wire logic [1:0] chan_index,
   output logic [11:0] conv_result
);
   timeunit 1ns;
   timeprecision 1ps;
   // pattern is a palindrome for channel 1 only, so bit order faults show on the other channels
   assign conv_result = {chan_index, ~chan_index, 8'h96};
endmodule // asc_analog_model

`default_nettype wire

// ==== verification/asc_props.sv ====
// pin-level checker for the conversion control block
// assumes it is bound to asc_conv_ctrl and the mode pins stay put while selected
`default_nettype none

module asc_props
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic chan_sel_lo,
   input wire logic chan_sel_hi,
   input wire logic mode_sel_a,
   input wire logic mode_sel_b,
   input wire logic [asc_pkg::RES_BITS-1:0] conv_result,
   input wire logic data_out,
   input wire logic data_oe,
   input wire logic sample_strobe,
   input wire logic sample_strobe_oe,
   input wire logic [1:0] chan_index
);
   timeunit 1ns;
   timeprecision 1ps;
   import asc_pkg::*;
   logic [5:0] sel_cnt_r;
   logic bad_mode;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // edges since select was sampled low, saturating
   always_ff @(posedge clock)
   begin
      if (!rst_b || cs_b)
         sel_cnt_r <= 6'h00;
      else if (sel_cnt_r != 6'h3f)
         sel_cnt_r <= sel_cnt_r + 6'h01;
   end
   assign bad_mode = mode_sel_a && !mode_sel_b;
   sequence s_pulse;
      sample_strobe ##1 !sample_strobe [*5];
   endsequence
   property p_pulse;
      $rose(sample_strobe) |-> s_pulse;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("strobe not a lone pulse");
   property p_start;
      (sel_cnt_r inside {[6'h01:6'h0f]} && !bad_mode) |-> sample_strobe == (sel_cnt_r == 6'h0f);
   endproperty
   a_start: assert property (p_start)
      else $error("strobe at wrong time after select");
   property p_float;
      cs_b [*3] |=> !data_oe && !sample_strobe_oe;
   endproperty
   a_float: assert property (p_float)
      else $error("outputs driven while deselected");
   property p_first;
      (sel_cnt_r == 6'h15 && !bad_mode) |-> data_out ==
         ((mode_sel_b && !mode_sel_a) ? $past(conv_result[0], 3) : $past(conv_result[11], 3));
   endproperty
   a_first: assert property (p_first)
      else $error("first data bit wrong");
   property p_halt;
      (sel_cnt_r == 6'h21 && !mode_sel_a && !mode_sel_b)
         |-> (data_oe && !data_out && !sample_strobe) [*8];
   endproperty
   a_halt: assert property (p_halt)
      else $error("single shot did not halt low");
   property p_period;
      disable iff (!rst_b || cs_b) (sample_strobe && mode_sel_b) |-> ##18 sample_strobe;
   endproperty
   a_period: assert property (p_period)
      else $error("continuous strobe period wrong");
   property p_bad;
      (bad_mode && !cs_b) |-> !sample_strobe && !data_out;
   endproperty
   a_bad: assert property (p_bad)
      else $error("disabled mode produced activity");
   property p_chan;
      sample_strobe |-> chan_index == {chan_sel_hi, chan_sel_lo};
   endproperty
   a_chan: assert property (p_chan)
      else $error("channel index wrong at strobe");
endmodule // asc_props

bind asc_conv_ctrl asc_props asc_props_i (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
   .chan_sel_lo(chan_sel_lo), .chan_sel_hi(chan_sel_hi), .mode_sel_a(mode_sel_a),
   .mode_sel_b(mode_sel_b), .conv_result(conv_result), .data_out(data_out),
   .data_oe(data_oe), .sample_strobe(sample_strobe), .sample_strobe_oe(sample_strobe_oe),
   .chan_index(chan_index));

`default_nettype wire

// ==== verification/asc_conv_ctrl_tb.sv ====
// self-checking bench for the conversion control block
// assumes the analog model answers at once on chan_index
`default_nettype none

module asc_conv_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import asc_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic cs_b = 1'b1;
   logic [1:0] chan = 2'h0;
   logic [1:0] mode = 2'h0;
   logic [11:0] conv_result;
   logic data_out, data_oe, sample_strobe, sample_strobe_oe;
   logic [1:0] chan_index;
   int miscompares = 0;
   int checks = 0;

   initial forever #5 clock = ~clock;

   asc_conv_ctrl asc_conv_ctrl_i (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
      .chan_sel_lo(chan[0]), .chan_sel_hi(chan[1]), .mode_sel_a(mode[1]),
      .mode_sel_b(mode[0]), .conv_result(conv_result), .data_out(data_out),
      .data_oe(data_oe), .sample_strobe(sample_strobe),
      .sample_strobe_oe(sample_strobe_oe), .chan_index(chan_index));
   asc_analog_model asc_analog_model_i (.chan_index(chan_index), .conv_result(conv_result));

   task close_out;
      if (miscompares == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [11:0] exp_word(input logic [1:0] c);
      return {c, ~c, 8'h96};
   endfunction

   // deselect long enough for the sync stages, then select
   task start(input logic [1:0] m, input logic [1:0] c);
      @(posedge clock);
      cs_b <= 1'b1;
      // mode only moves while deselected, and a new shot needs a high phase
      mode <= m;
      chan <= c;
      repeat (4) @(posedge clock);
      cs_b <= 1'b0;
   endtask

   task stop;
      @(posedge clock);
      cs_b <= 1'b1;
      repeat (4) @(negedge clock);
      chk(12'({data_oe, sample_strobe_oe}), 12'h000);
   endtask

   task get_word(input logic lsb, output logic [11:0] w);
      for (int i = 0; i < 12; i++)
      begin
         @(negedge clock);
         w[lsb ? i : 11 - i] = data_out;
      end
   endtask

   task t_single(input logic [1:0] c);
      logic [11:0] w;
      start(2'h0, c);
      repeat (5) @(negedge clock);
      chk(12'({data_oe, sample_strobe_oe}), 12'h003);
      repeat (11) @(negedge clock);
      chk(12'({chan_index, sample_strobe}), 12'({c, 1'b1}));
      @(negedge clock);
      chk(12'(sample_strobe), 12'h000);
      repeat (4) @(negedge clock);
      get_word(1'b0, w);
      chk(w, exp_word(c));
      repeat (10)
      begin
         @(negedge clock);
         chk(12'({data_oe, data_out, sample_strobe}), 12'h004);
      end
      stop;
   endtask

   // channel moves after the first strobe, well before the second
   task t_cont(input logic [1:0] m, input logic [1:0] c1, input logic [1:0] c2);
      logic [11:0] w;
      start(m, c1);
      repeat (16) @(negedge clock);
      chk(12'(sample_strobe), 12'h001);
      @(posedge clock);
      chan <= c2;
      // strobe fell at this edge; first bit lands five edges on
      repeat (5) @(negedge clock);
      get_word(m == 2'h1, w);
      chk(w, exp_word(c1));
      @(negedge clock);
      chk(12'({chan_index, sample_strobe}), 12'({c2, 1'b1}));
      repeat (5) @(negedge clock);
      get_word(m == 2'h1, w);
      chk(w, exp_word(c2));
      stop;
   endtask

   task t_bad;
      start(2'h2, 2'h1);
      repeat (40)
      begin
         @(negedge clock);
         chk(12'({sample_strobe, data_out}), 12'h000);
      end
      stop;
   endtask

   initial
   begin
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      for (int c = 0; c < 4; c++)
         t_single(2'(c));
      t_cont(2'h1, 2'h2, 2'h3);
      t_cont(2'h3, 2'h0, 2'h1);
      t_bad;
      close_out;
   end
endmodule // asc_conv_ctrl_tb

`default_nettype wire
